// >>> src/ssp_pkg.sv
// constants, types and the register map of the synchronous serial port
// assumes a 32-bit apb master and a byte-wide register file
package ssp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_BUFFER = 8'h08;
  localparam logic [7:0] OFF_SLAVE_ADDR = 8'h0c;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h10;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFF_PORT_C_DIR = 8'h18;
  localparam logic [7:0] OFF_PORT_A_DIR = 8'h1c;
  // control register fields
  localparam int CTL_WRITE_COLLISION_FLAG = 7;
  localparam int CTL_OVF = 6;
  localparam int CTL_EN = 5;
  localparam int CTL_CKP = 4;
  // status register fields
  localparam int ST_SMP = 7;
  localparam int ST_CKE = 6;
  localparam int ST_DA = 5;
  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;
  // flag/enable bit of this port, direction bits of its pins
  localparam int IRQ_PORT = 3;
  localparam int DIR_SDA = 7;
  localparam int DIR_SCK = 6;
  localparam int DIR_SDO = 4;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  // master half-bit lengths in pclk cycles
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  typedef enum logic [3:0] {
    MODE_MASTER_DIV4 = 4'b0000,
    MODE_MASTER_DIV16 = 4'b0001,
    MODE_MASTER_DIV64 = 4'b0010,
    MODE_MASTER_TIMER = 4'b0011,
    MODE_SLAVE_SELECT = 4'b0100,
    MODE_SLAVE_FREE = 4'b0101,
    MODE_I2C_7BIT = 4'b0110,
    MODE_I2C_10BIT = 4'b0111,
    MODE_I2C_FIRMWARE = 4'b1011,
    MODE_I2C_7BIT_IRQ = 4'b1110,
    MODE_I2C_10BIT_IRQ = 4'b1111
  } mode_e;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX = 3'b001,
    I2C_ACK = 3'b010,
    I2C_TX = 3'b011,
    I2C_TACK = 3'b100
  } i2c_e;
  typedef struct packed {
    logic clk;
    logic data;
    logic sel_n;
  } pins_s;
  localparam pins_s PINS_RST = 3'b011;
endpackage

// >>> src/sync_serial_port.sv
// synchronous serial port: spi master/slave and i2c slave behind apb
// assumes pins arrive asynchronously; sleep_req and timer_tick are on pclk
`timescale 1ns/100ps
module sync_serial_port #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_req,
  input wire logic timer_tick,
  input wire logic clk_pin_in,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  input wire logic serial_in_pin,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic serial_out_pin,
  output logic serial_out_pin_oe,
  input wire logic select_n_pin,
  output logic wake_request
);
  if (ADDR_WIDTH < 9) begin : g_addr_check
    $error("address bus must be at least 9 bits wide");
  end

  ssp_pkg::pins_s pin_meta, pin_sync, pin_prev;
  logic [7:0] control, buffer, slave_address, irq_enable;
  logic [7:0] port_c_direction, port_a_direction;
  logic sample_phase_bit, cke, bf, port_irq_flag;
  logic [7:0] sr;
  logic [3:0] bit_cnt;
  logic [5:0] div_cnt, half_len;
  logic tx_bit, master_run, half, sck_level, spi_done;
  ssp_pkg::i2c_e i_state;
  logic [3:0] i_cnt;
  logic [7:0] i_sr;
  logic is_addr, ack_low, data_addr, rw_bit, start_seen, stop_seen, ua;
  logic i_store, i_flag, i_ovf, i_clr_ckp;
  logic enabled, clock_polarity_bit, spi_master, spi_slave, i2c_on, i2c_addressed;
  logic ss_irq, ten_bit, ss_ctl, slave_sel, ss_reset, first_level;
  logic clk_rise, clk_fall, lead, trail, sample, shift_edge, tick;
  logic acc, wr, rd, busy, buf_ok, collision, buf_rd, addr_wr, mapped;
  logic scl_high, i2c_start, i2c_stop, addr_match, rx_ok;
  logic [3:0] mode;
  logic [7:0] rdata;

  function automatic logic hit(input logic [ADDR_WIDTH-1:0] a,
                               input logic [7:0] off);
    return (a[7:0] == off) && (a[ADDR_WIDTH-1:8] == '0);
  endfunction

  // mode decode from the control register
  assign enabled = control[ssp_pkg::CTL_EN];
  assign clock_polarity_bit = control[ssp_pkg::CTL_CKP];
  assign mode = control[3:0];
  assign spi_master = enabled & (mode[3:2] == 2'b00);
  assign spi_slave = enabled & ((mode == ssp_pkg::MODE_SLAVE_SELECT) |
                     (mode == ssp_pkg::MODE_SLAVE_FREE));
  assign i2c_on = enabled & ((mode == ssp_pkg::MODE_I2C_7BIT) |
                  (mode == ssp_pkg::MODE_I2C_10BIT) |
                  (mode == ssp_pkg::MODE_I2C_FIRMWARE) |
                  (mode == ssp_pkg::MODE_I2C_7BIT_IRQ) |
                  (mode == ssp_pkg::MODE_I2C_10BIT_IRQ));
  assign i2c_addressed = i2c_on & (mode != ssp_pkg::MODE_I2C_FIRMWARE);
  assign ss_irq = i2c_on & (mode[3:2] == 2'b11 |
                  mode == ssp_pkg::MODE_I2C_FIRMWARE);
  assign ten_bit = (mode == ssp_pkg::MODE_I2C_10BIT) |
                   (mode == ssp_pkg::MODE_I2C_10BIT_IRQ);
  assign ss_ctl = enabled & (mode == ssp_pkg::MODE_SLAVE_SELECT);
  assign slave_sel = ss_ctl ? ~pin_sync.sel_n : 1'b1;
  assign ss_reset = ss_ctl & pin_sync.sel_n;

  // clock edges seen on the synchronised pin, sorted by polarity
  assign clk_rise = pin_sync.clk & ~pin_prev.clk;
  assign clk_fall = ~pin_sync.clk & pin_prev.clk;
  assign lead = clock_polarity_bit ? clk_fall : clk_rise;
  assign trail = clock_polarity_bit ? clk_rise : clk_fall;
  assign sample = cke ? lead : trail;
  assign shift_edge = cke ? trail : lead;
  assign first_level = clock_polarity_bit ^ ~cke;

  // master bit rate
  always_comb begin
    case (mode[1:0])
      2'b00: half_len = ssp_pkg::HALF_DIV4;
      2'b01: half_len = ssp_pkg::HALF_DIV16;
      default: half_len = ssp_pkg::HALF_DIV64;
    endcase
  end
  assign tick = (mode == ssp_pkg::MODE_MASTER_TIMER) ? timer_tick :
                (div_cnt == half_len - 6'h01);

  // apb access decode; the access edge is the one with pready high
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign busy = master_run | (spi_slave & (bit_cnt != 4'h0)) |
                (i2c_on & (i_state != ssp_pkg::I2C_IDLE) &
                 (i_cnt != 4'h0));
  assign buf_ok = wr & hit(paddr, ssp_pkg::OFF_BUFFER) & ~busy;
  assign collision = wr & hit(paddr, ssp_pkg::OFF_BUFFER) & busy;
  assign buf_rd = rd & hit(paddr, ssp_pkg::OFF_BUFFER);
  assign addr_wr = wr & hit(paddr, ssp_pkg::OFF_SLAVE_ADDR);

  // i2c bus conditions
  assign scl_high = pin_sync.clk & pin_prev.clk;
  assign i2c_start = scl_high & pin_prev.data & ~pin_sync.data;
  assign i2c_stop = scl_high & ~pin_prev.data & pin_sync.data;
  // address zero never matches, so general call is never answered
  assign addr_match = (i_sr[7:1] == slave_address[7:1]) &&
                      (i_sr[7:1] != 7'h00);
  assign rx_ok = ~bf & ~control[ssp_pkg::CTL_OVF];

  // two-stage synchronisers; only pin_sync and later are looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta <= ssp_pkg::PINS_RST;
      pin_sync <= ssp_pkg::PINS_RST;
      pin_prev <= ssp_pkg::PINS_RST;
    end else begin
      pin_meta <= {clk_pin_in, serial_in_pin, select_n_pin};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // spi shift engine, master and slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr <= 8'h00;
      bit_cnt <= 4'h0;
      tx_bit <= 1'b0;
      master_run <= 1'b0;
      half <= 1'b0;
      div_cnt <= 6'h00;
      sck_level <= 1'b0;
      spi_done <= 1'b0;
    end else begin
      spi_done <= 1'b0;
      if ((~spi_master & ~spi_slave) | ss_reset) begin
        bit_cnt <= 4'h0;
        master_run <= 1'b0;
        half <= 1'b0;
        div_cnt <= 6'h00;
        sck_level <= clock_polarity_bit;
        // a deselected slave must still take the byte it is to send
        if (buf_ok) begin
          sr <= pwdata[7:0];
          tx_bit <= pwdata[7];
        end
      end else if (buf_ok) begin
        sr <= pwdata[7:0];
        tx_bit <= pwdata[7];
        bit_cnt <= 4'h0;
        if (spi_master) begin
          master_run <= 1'b1;
          half <= 1'b0;
          div_cnt <= 6'h00;
          sck_level <= first_level;
        end
      end else if (spi_master) begin
        if (!master_run) begin
          sck_level <= clock_polarity_bit;
        end else if (!sleep_req) begin
          div_cnt <= tick ? 6'h00 : div_cnt + 6'h01;
          if (tick && !half) begin
            half <= 1'b1;
            sck_level <= ~first_level;
            if (!sample_phase_bit) begin
              sr <= {sr[6:0], pin_sync.data};
            end
          end else if (tick) begin
            half <= 1'b0;
            if (sample_phase_bit) begin
              sr <= {sr[6:0], pin_sync.data};
            end
            tx_bit <= sample_phase_bit ? sr[6] : sr[7];
            if (bit_cnt == 4'h7) begin
              master_run <= 1'b0;
              spi_done <= 1'b1;
              bit_cnt <= 4'h0;
              sck_level <= clock_polarity_bit;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              sck_level <= first_level;
            end
          end
        end
      end else if (slave_sel) begin
        if (sample) begin
          sr <= {sr[6:0], pin_sync.data};
          if (bit_cnt == 4'h7) begin
            spi_done <= 1'b1;
            bit_cnt <= 4'h0;
          end else begin
            bit_cnt <= bit_cnt + 4'h1;
          end
        end else if (shift_edge) begin
          tx_bit <= sr[7];
        end
      end
    end
  end

  // i2c slave and start/stop detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i_state <= ssp_pkg::I2C_IDLE;
      i_cnt <= 4'h0;
      i_sr <= 8'h00;
      is_addr <= 1'b0;
      ack_low <= 1'b0;
      data_addr <= 1'b0;
      rw_bit <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      ua <= 1'b0;
      i_store <= 1'b0;
      i_flag <= 1'b0;
      i_ovf <= 1'b0;
      i_clr_ckp <= 1'b0;
    end else if (!i2c_on) begin
      i_state <= ssp_pkg::I2C_IDLE;
      i_cnt <= 4'h0;
      ack_low <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      ua <= 1'b0;
      i_store <= 1'b0;
      i_flag <= 1'b0;
      i_ovf <= 1'b0;
      i_clr_ckp <= 1'b0;
    end else begin
      i_store <= 1'b0;
      i_flag <= 1'b0;
      i_ovf <= 1'b0;
      i_clr_ckp <= 1'b0;
      if (addr_wr) begin
        ua <= 1'b0;
      end
      if (buf_ok) begin
        i_sr <= pwdata[7:0];
      end
      if (i2c_start) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
        i_flag <= ss_irq;
        ack_low <= 1'b0;
        i_cnt <= 4'h0;
        is_addr <= 1'b1;
        i_state <= i2c_addressed ? ssp_pkg::I2C_RX : ssp_pkg::I2C_IDLE;
      end else if (i2c_stop) begin
        stop_seen <= 1'b1;
        start_seen <= 1'b0;
        i_flag <= ss_irq;
        ack_low <= 1'b0;
        i_state <= ssp_pkg::I2C_IDLE;
      end else begin
        case (i_state)
          ssp_pkg::I2C_RX: begin
            if (clk_rise) begin
              i_sr <= {i_sr[6:0], pin_sync.data};
              i_cnt <= i_cnt + 4'h1;
            end else if (clk_fall && i_cnt == 4'h8) begin
              if (is_addr && !addr_match) begin
                i_state <= ssp_pkg::I2C_IDLE;
              end else begin
                i_store <= rx_ok;
                ack_low <= rx_ok;
                i_ovf <= ~rx_ok;
                data_addr <= ~is_addr;
                if (is_addr) begin
                  rw_bit <= i_sr[0];
                  ua <= ten_bit;
                end
                i_state <= ssp_pkg::I2C_ACK;
              end
            end
          end
          ssp_pkg::I2C_ACK: begin
            if (clk_fall) begin
              ack_low <= 1'b0;
              i_flag <= 1'b1;
              i_cnt <= 4'h0;
              if (ack_low && is_addr && rw_bit) begin
                i_clr_ckp <= 1'b1; // stretch until data is loaded
                i_state <= ssp_pkg::I2C_TX;
              end else begin
                is_addr <= 1'b0;
                i_state <= ssp_pkg::I2C_RX;
              end
            end
          end
          ssp_pkg::I2C_TX: begin
            if (clk_fall) begin
              i_sr <= {i_sr[6:0], 1'b0};
              i_cnt <= i_cnt + 4'h1;
              if (i_cnt == 4'h7) begin
                i_state <= ssp_pkg::I2C_TACK;
              end
            end
          end
          ssp_pkg::I2C_TACK: begin
            if (clk_rise && pin_sync.data) begin
              rw_bit <= 1'b0; // no acknowledge: transfer complete
              data_addr <= 1'b0;
              i_state <= ssp_pkg::I2C_IDLE;
            end else if (clk_fall) begin
              i_flag <= 1'b1;
              i_clr_ckp <= 1'b1;
              data_addr <= 1'b1;
              i_cnt <= 4'h0;
              i_state <= ssp_pkg::I2C_TX;
            end
          end
          default: i_state <= ssp_pkg::I2C_IDLE;
        endcase
      end
    end
  end

  // control register; hardware sets win over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= ssp_pkg::CONTROL_RST;
    end else begin
      if (wr && hit(paddr, ssp_pkg::OFF_CONTROL)) begin
        control <= pwdata[7:0];
      end else if (i_clr_ckp) begin
        control[ssp_pkg::CTL_CKP] <= 1'b0;
      end
      if (collision) begin
        control[ssp_pkg::CTL_WRITE_COLLISION_FLAG] <= 1'b1;
      end
      if ((spi_done & bf) | i_ovf) begin
        control[ssp_pkg::CTL_OVF] <= 1'b1;
      end
    end
  end

  // status bits owned by software or by the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_phase_bit <= 1'b0;
      cke <= 1'b0;
      bf <= 1'b0;
    end else begin
      if (wr && hit(paddr, ssp_pkg::OFF_STATUS)) begin
        sample_phase_bit <= pwdata[ssp_pkg::ST_SMP];
        cke <= pwdata[ssp_pkg::ST_CKE];
      end
      if (buf_rd) begin
        bf <= 1'b0;
      end
      if ((spi_done & ~bf) | i_store) begin
        bf <= 1'b1;
      end
    end
  end

  // transfer buffer keeps its content through every reset
  always_ff @(posedge pclk) begin
    if (spi_done && !bf) begin
      buffer <= sr;
    end else if (i_store) begin
      buffer <= i_sr;
    end else if (buf_ok) begin
      buffer <= pwdata[7:0];
    end
  end

  // plain software registers and the port flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_address <= ssp_pkg::ADDR_RST;
      irq_enable <= ssp_pkg::IRQ_RST;
      port_c_direction <= ssp_pkg::DIR_RST;
      port_a_direction <= ssp_pkg::DIR_RST;
      port_irq_flag <= 1'b0;
    end else begin
      if (addr_wr) begin
        slave_address <= pwdata[7:0];
      end
      if (wr && hit(paddr, ssp_pkg::OFF_IRQ_ENABLE)) begin
        irq_enable <= pwdata[7:0];
      end
      if (wr && hit(paddr, ssp_pkg::OFF_PORT_C_DIR)) begin
        port_c_direction <= pwdata[7:0];
      end
      if (wr && hit(paddr, ssp_pkg::OFF_PORT_A_DIR)) begin
        port_a_direction <= pwdata[7:0];
      end
      if (wr && hit(paddr, ssp_pkg::OFF_IRQ_FLAGS)) begin
        port_irq_flag <= pwdata[ssp_pkg::IRQ_PORT];
      end
      if (spi_done | i_flag) begin
        port_irq_flag <= 1'b1;
      end
    end
  end

  // read mux; the shift register has no address of its own
  always_comb begin
    mapped = 1'b1;
    rdata = 8'h00;
    case (paddr[7:0])
      ssp_pkg::OFF_CONTROL: rdata = control;
      ssp_pkg::OFF_STATUS: rdata = {sample_phase_bit, cke, data_addr, stop_seen,
                                    start_seen, rw_bit, ua, bf};
      ssp_pkg::OFF_BUFFER: rdata = buffer;
      ssp_pkg::OFF_SLAVE_ADDR: rdata = slave_address;
      ssp_pkg::OFF_IRQ_FLAGS: rdata = {4'h0, port_irq_flag, 3'h0};
      ssp_pkg::OFF_IRQ_ENABLE: rdata = irq_enable;
      ssp_pkg::OFF_PORT_C_DIR: rdata = port_c_direction;
      ssp_pkg::OFF_PORT_A_DIR: rdata = port_a_direction;
      default: mapped = 1'b0;
    endcase
    if (paddr[ADDR_WIDTH-1:8] != '0) begin
      mapped = 1'b0;
    end
  end

  // apb answer with one wait state, all outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready) begin
        prdata <= mapped ? {24'h000000, rdata} : 32'h00000000;
      end
    end
  end

  // pin drivers; i2c drives only low, and only on input-direction pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_pin_out <= 1'b0;
      clk_pin_oe <= 1'b0;
      data_pin_out <= 1'b0;
      data_pin_oe <= 1'b0;
      serial_out_pin <= 1'b0;
      serial_out_pin_oe <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      clk_pin_out <= spi_master & sck_level;
      clk_pin_oe <= (spi_master & ~port_c_direction[ssp_pkg::DIR_SCK]) |
                    (i2c_on & port_c_direction[ssp_pkg::DIR_SCK] &
                     (i_state == ssp_pkg::I2C_TX) & ~clock_polarity_bit);
      data_pin_out <= 1'b0;
      data_pin_oe <= i2c_on & port_c_direction[ssp_pkg::DIR_SDA] &
                     (ack_low | ((i_state == ssp_pkg::I2C_TX) &
                     ~i_sr[7]));
      serial_out_pin <= tx_bit;
      serial_out_pin_oe <= ~port_c_direction[ssp_pkg::DIR_SDO] &
                           (spi_master | (spi_slave & slave_sel));
      wake_request <= port_irq_flag & irq_enable[ssp_pkg::IRQ_PORT];
    end
  end
endmodule

// >>> tb/ssp_properties.sv
// checker for the serial port, watching only the top module's ports
// assumes register writes land at the apb ready edge
`timescale 1ns/100ps
module ssp_properties #(
  parameter int ADDR_WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic select_n_pin,
  input wire logic serial_out_pin_oe,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic wake_request
);
  logic [7:0] ctl;
  logic [7:0] dirc;
  logic [7:0] ien;
  logic wr;
  logic slv;
  logic i2c;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadows of software-written fields; hardware-set bits are not needed
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl <= 8'h00;
      dirc <= 8'hff;
      ien <= 8'h00;
    end else if (wr) begin
      if (paddr == ADDR_WIDTH'(ssp_pkg::OFF_CONTROL)) ctl <= pwdata[7:0];
      if (paddr == ADDR_WIDTH'(ssp_pkg::OFF_PORT_C_DIR)) dirc <= pwdata[7:0];
      if (paddr == ADDR_WIDTH'(ssp_pkg::OFF_IRQ_ENABLE)) ien <= pwdata[7:0];
    end
  end
  assign slv = ctl[5] && ctl[3:0] == 4'h4 && !dirc[4];
  assign i2c = ctl[5] && ctl[3:0] inside {4'h6, 4'h7, 4'hb, 4'he, 4'hf};
  // one wait state, then ready for a single cycle
  sequence s_answer;
    !pready ##1 pready ##1 !pready;
  endsequence
  a_apb_wait: assert property (
    psel && penable && !$past(penable) |-> s_answer)
    else $error("apb answer not after one wait state");
  a_unmapped_err: assert property (
    psel && penable && pready && paddr >= ADDR_WIDTH'(8'h20) |-> pslverr)
    else $error("unmapped access without slave error");
  a_reset_idle: assert property (
    !$past(presetn) |-> !pready && !serial_out_pin_oe && !clk_pin_oe
      && !wake_request)
    else $error("outputs active right after reset");
  a_dir_blocks_oe: assert property (
    $past(dirc[4]) && $past(dirc[4], 2) |-> !serial_out_pin_oe)
    else $error("data output driven while set as input");
  a_sel_drive: assert property (
    (slv && !select_n_pin) [*6] |-> serial_out_pin_oe)
    else $error("selected slave does not drive data output");
  a_sel_release: assert property (
    slv && $rose(select_n_pin) |-> ##[1:5] !serial_out_pin_oe)
    else $error("data output still driven after deselect");
  a_off_quiet: assert property (
    !ctl[5] && !$past(ctl[5]) |-> !serial_out_pin_oe && !clk_pin_oe
      && !data_pin_oe)
    else $error("disabled port drives a pin");
  a_wake_gated: assert property (
    wake_request |-> $past(ien[ssp_pkg::IRQ_PORT]))
    else $error("wake request while port interrupt disabled");
  a_i2c_drain: assert property (
    i2c && $past(i2c) |-> !clk_pin_out && !data_pin_out)
    else $error("i2c pin driven high");
endmodule
bind sync_serial_port ssp_properties #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .select_n_pin, .serial_out_pin_oe, .clk_pin_out, .clk_pin_oe,
  .data_pin_out, .data_pin_oe, .wake_request
);

// >>> tb/spi_host_model.sv
// spi host on the far side of the port: clock, select and data out
// assumes a 48 ns serial clock that stands low between frames
`timescale 1ns/100ps
module spi_host_model (
  output logic sck,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  // idle bus: clock low, slave deselected
  initial begin
    sck = 1'h0;
    ss_n = 1'h1;
    mosi = 1'h0;
  end
  // nb bits msb first; a short nb aborts the byte mid-way
  task automatic frame(input logic [7:0] tx, input int nb,
    output logic [7:0] rx);
    rx = 8'h00;
    ss_n = 1'h0;
    mosi = tx[7];
    #24;
    for (int i = 7; i > 7 - nb; i--) begin
      mosi = tx[i];
      #24 sck = 1'h1;
      rx[i] = miso;
      #24 sck = 1'h0;
    end
    #24 ss_n = 1'h1;
    mosi = ~mosi; // no stale level once deselected
  endtask
endmodule

// >>> tb/sync_serial_port_tb.sv
// self-checking bench: registers, spi master loop-back, spi slave
// assumes the host model on the pins and apb with one wait state
`timescale 1ns/100ps
module sync_serial_port_tb;
  logic pclk, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic sleep_req = 1'h0, timer_tick = 1'h0, lp = 1'h0, e, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic clk_pin_out, clk_pin_oe, data_pin_out, data_pin_oe;
  logic serial_out_pin, serial_out_pin_oe, wake_request;
  logic [7:0] q, rx;
  wire sck, ss_n, mosi;
  int err_count = 0, cmp_count = 0, cyc = 0;
  // rows: address, reset value, write data, read-back value
  logic [31:0] regs [8] = '{32'h00002626, 32'h0400ffc0, 32'h0c00a6a6,
    32'h10000808, 32'h1400ffff, 32'h18ffafaf, 32'h1cff5a5a, 32'h20005500};
  logic [3:0] codes [6] = '{4'h5, 4'h6, 4'h7, 4'hb, 4'he, 4'hf};
  // master rows: mode, polarity, edge, byte
  logic [13:0] mrow [4] = '{14'h05a5, 14'h083c, 14'h0f81, 14'h025e};
  // pin levels from the port's enables, loop-back aside; loose lines never hold a level
  wire ck_w = clk_pin_oe ? clk_pin_out : sck;
  wire sd_w = data_pin_oe ? 1'h0 : lp ? serial_out_pin : mosi;
  wire miso = serial_out_pin_oe ? serial_out_pin : ~serial_out_pin;
  sync_serial_port i_sync_serial_port (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleep_req, .timer_tick, .clk_pin_in(ck_w),
    .clk_pin_out, .clk_pin_oe, .serial_in_pin(sd_w), .data_pin_out,
    .data_pin_oe, .serial_out_pin, .serial_out_pin_oe,
    .select_n_pin(ss_n), .wake_request
  );
  spi_host_model i_spi_host_model (.sck, .ss_n, .mosi, .miso);
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // half-bit tick for the timer mode, and the hang limit
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    timer_tick <= cyc[1:0] == 2'h0;
    if (cyc == 40000) begin
      err_count++;
      stop_test();
    end
  end
  // one apb transfer; waits for ready however long the slave takes
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [7:0] g, x);
    cmp_count++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    foreach (regs[i]) begin
      apb(1'h0, regs[i][31:24], 8'h00);
      chk("reset value", q, regs[i][23:16]);
      apb(1'h1, regs[i][31:24], regs[i][15:8]);
      apb(1'h0, regs[i][31:24], 8'h00);
      chk("read back", q, regs[i][7:0]);
      chk("slave error", {7'h0, e}, {7'h0, regs[i][31:24] == 8'h20});
    end
    chk("wake", {7'h0, wake_request}, 8'h01);
    apb(1'h1, ssp_pkg::OFF_IRQ_FLAGS, 8'h00);
    foreach (codes[i]) begin
      apb(1'h1, ssp_pkg::OFF_CONTROL, {4'h2, codes[i]});
      apb(1'h0, ssp_pkg::OFF_CONTROL, 8'h00);
      chk("mode code", q, {4'h2, codes[i]});
    end
    // master rows: data out looped back to data in
    lp <= 1'h1;
    foreach (mrow[i]) begin
      apb(1'h1, ssp_pkg::OFF_CONTROL, 8'h00);
      // fast modes sample at bit end: the loop-back path takes three cycles
      apb(1'h1, ssp_pkg::OFF_STATUS,
          {mrow[i][11] ~^ mrow[i][10], mrow[i][8], 6'h00});
      apb(1'h1, ssp_pkg::OFF_CONTROL, {3'h1, mrow[i][9], mrow[i][13:10]});
      apb(1'h1, ssp_pkg::OFF_BUFFER, mrow[i][7:0]);
      @(posedge pclk);
      chk("first bit", {7'h0, serial_out_pin}, {7'h0, mrow[i][7]});
      do apb(1'h0, ssp_pkg::OFF_STATUS, 8'h00); while (q[0] !== 1'h1);
      apb(1'h0, ssp_pkg::OFF_BUFFER, 8'h00);
      chk("loop byte", q, mrow[i][7:0]);
      chk("idle clock", {7'h0, clk_pin_out}, {7'h0, mrow[i][9]});
    end
    // sleep must freeze a master byte; a reset then aborts a second one
    apb(1'h1, ssp_pkg::OFF_BUFFER, 8'h96);
    sleep_req <= 1'h1;
    repeat (8) @(posedge pclk);
    rx = {6'h0, clk_pin_out, serial_out_pin};
    repeat (40) @(posedge pclk);
    chk("frozen pins", {6'h0, clk_pin_out, serial_out_pin}, rx);
    sleep_req <= 1'h0;
    do apb(1'h0, ssp_pkg::OFF_STATUS, 8'h00); while (q[0] !== 1'h1);
    apb(1'h0, ssp_pkg::OFF_BUFFER, 8'h00);
    chk("resumed byte", q, 8'h96);
    // a second byte is cut short by the reset
    apb(1'h1, ssp_pkg::OFF_BUFFER, 8'h69);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    sleep_req <= 1'h0;
    @(posedge pclk);
    apb(1'h0, ssp_pkg::OFF_CONTROL, 8'h00);
    chk("control after reset", q, 8'h00);
    chk("sdo drive", {7'h0, serial_out_pin_oe}, 8'h00);
    // slave with select control: abort mid-byte, then a byte in sleep
    lp <= 1'h0;
    apb(1'h1, ssp_pkg::OFF_PORT_C_DIR, 8'haf);
    apb(1'h1, ssp_pkg::OFF_IRQ_ENABLE, 8'h08);
    apb(1'h1, ssp_pkg::OFF_STATUS, 8'h40);
    apb(1'h1, ssp_pkg::OFF_CONTROL, 8'h24);
    apb(1'h1, ssp_pkg::OFF_BUFFER, 8'h3c);
    i_spi_host_model.frame(8'hff, 4, rx);
    repeat (4) @(posedge pclk);
    apb(1'h1, ssp_pkg::OFF_BUFFER, 8'h3c);
    apb(1'h0, ssp_pkg::OFF_CONTROL, 8'h00);
    chk("no collision", q, 8'h24);
    sleep_req <= 1'h1;
    i_spi_host_model.frame(8'ha5, 8, rx);
    @(posedge pclk);
    chk("slave sent", rx, 8'h3c);
    do apb(1'h0, ssp_pkg::OFF_STATUS, 8'h00); while (q[0] !== 1'h1);
    chk("wake in sleep", {7'h0, wake_request}, 8'h01);
    sleep_req <= 1'h0;
    apb(1'h0, ssp_pkg::OFF_BUFFER, 8'h00);
    chk("slave got", q, 8'ha5);
    stop_test();
  end
endmodule
